// File: rtl/rcl_pkg.sv
// package of constants for the remote coordination line block
package rcl_pkg;
	localparam int RCL_NLINES = 7;
	// line indices
	localparam int RCL_L_SETUP = 0;
	localparam int RCL_L_START = 1;
	localparam int RCL_L_HALT = 2;
	localparam int RCL_L_LIVE = 3;
	localparam int RCL_L_READY = 4;
	localparam int RCL_L_STOP = 5;
	localparam int RCL_L_INJECT = 6;
	// register byte addresses
	localparam logic [7:0] RCL_A_CTRL = 8'h00;
	localparam logic [7:0] RCL_A_LINES = 8'h04;
	localparam logic [7:0] RCL_A_STATUS = 8'h08;
	localparam logic [7:0] RCL_A_MASK = 8'h0C;
	localparam logic [7:0] RCL_A_PHASE = 8'h10;
	localparam logic [6:0] RCL_CTRL_RESET = 7'h00;
	localparam logic [6:0] RCL_MASK_RESET = 7'h00;
	localparam int RCL_SYNC_STAGES = 2;
	// status bits: one per asserted line plus a sequence fault
	localparam int RCL_EV_SEQ = 7;
	localparam int RCL_NEV = 8;
	typedef enum logic [1:0] {
		RCL_IDLE = 2'b00,
		RCL_READY = 2'b01,
		RCL_RUN = 2'b11,
		RCL_STOPPING = 2'b10
	} rcl_phase_t;
endpackage : rcl_pkg

// File: rtl/rcl_sync.sv
// two-stage synchroniser for a vector of level inputs
`timescale 1ns/1ps
`default_nettype none
module rcl_sync #(
	parameter int WIDTH = 7,
	parameter int STAGES = 2
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_reg [STAGES];
	// reset to released level: high means false on the low-true lines, true on live and ready
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			for (int i = 0; i < STAGES; i++) begin
				stage_reg[i] <= '1;
			end
		end else begin
			stage_reg[0] <= async_in;
			for (int i = 1; i < STAGES; i++) begin
				stage_reg[i] <= stage_reg[i-1];
			end
		end
	end
	assign sync_out = stage_reg[STAGES-1];
endmodule : rcl_sync
`default_nettype wire

// File: rtl/rcl_edge.sv
// edge detector turning true-going line levels into one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module rcl_edge #(
	parameter int WIDTH = 7
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [WIDTH-1:0] level_in,
	output logic [WIDTH-1:0] rise_out
);
	logic [WIDTH-1:0] last_reg;
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			// start from the idle truth so the high-true lines show no false edge after reset
			last_reg <= level_in;
		end else begin
			last_reg <= level_in;
		end
	end
	assign rise_out = level_in & ~last_reg;
endmodule : rcl_edge
`default_nettype wire

// File: rtl/rcl_top.sv
// remote coordination line controller with apb register access
`timescale 1ns/1ps
`default_nettype none
module rcl_top
	import rcl_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// coordination lines, open collector: oe high pulls low
	input wire logic [RCL_NLINES-1:0] line_in,
	output logic [RCL_NLINES-1:0] line_out,
	output logic [RCL_NLINES-1:0] line_oe_out,
	// local status and reactions
	input wire logic fault_in,
	input wire logic local_ready_in,
	input wire logic powered_in,
	output logic halt_out,
	output logic all_live_out,
	output logic sys_ready_out,
	output logic setup_req_out,
	output logic start_out,
	output logic stop_out,
	output logic inject_req_out,
	output logic irq_out
);
	////////////////////////////////////////////////////////////////////////
	// line sensing
	logic [RCL_NLINES-1:0] sync_level;
	logic [RCL_NLINES-1:0] asserted;
	logic [RCL_NLINES-1:0] rise;

	rcl_sync #(
		.WIDTH(RCL_NLINES),
		.STAGES(RCL_SYNC_STAGES)
	) u_sync (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.async_in(line_in),
		.sync_out(sync_level)
	);

	// low-true lines invert; live and ready are high-true
	always_comb begin
		asserted = ~sync_level;
		asserted[RCL_L_LIVE] = sync_level[RCL_L_LIVE];
		asserted[RCL_L_READY] = sync_level[RCL_L_READY];
	end

	rcl_edge #(
		.WIDTH(RCL_NLINES)
	) u_edge (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.level_in(asserted),
		.rise_out(rise)
	);

	////////////////////////////////////////////////////////////////////////
	// registers
	logic [RCL_NLINES-1:0] ctrl_reg;
	logic [RCL_NLINES-1:0] mask_reg;
	logic [RCL_NEV-1:0] status_reg;
	logic [RCL_NEV-1:0] status_next;
	logic [31:0] rdata_next;
	rcl_phase_t phase_reg;
	rcl_phase_t phase_next;
	logic [RCL_NLINES-1:0] ctrl_wr;
	logic setup_wr;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic seq_fault;
	logic [RCL_NEV-1:0] events;

	function automatic logic rcl_hit(input logic [7:0] a, input logic [7:0] b);
		rcl_hit = (a == b);
	endfunction : rcl_hit

	assign setup_wr = psel_in & ~penable_in;
	assign wr_en = psel_in & penable_in & pwrite_in;
	assign rd_en = psel_in & penable_in & ~pwrite_in;
	assign addr_ok = rcl_hit(paddr_in, RCL_A_CTRL) | rcl_hit(paddr_in, RCL_A_LINES) |
		rcl_hit(paddr_in, RCL_A_STATUS) | rcl_hit(paddr_in, RCL_A_MASK) | rcl_hit(paddr_in, RCL_A_PHASE);
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in & penable_in & ~addr_ok;

	// software line requests, held until written again
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ctrl_reg <= RCL_CTRL_RESET;
		end else if (wr_en && rcl_hit(paddr_in, RCL_A_CTRL)) begin
			ctrl_reg <= pwdata_in[RCL_NLINES-1:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			mask_reg <= RCL_MASK_RESET;
		end else if (wr_en && rcl_hit(paddr_in, RCL_A_MASK)) begin
			mask_reg <= pwdata_in[RCL_NLINES-1:0];
		end
	end
	assign ctrl_wr = ctrl_reg;

	////////////////////////////////////////////////////////////////////////
	// line drive: oe pulls the wire low, the wire is never driven high
	always_comb begin
		line_out = '0;
		line_oe_out = ctrl_wr & ~((RCL_NLINES)'(1) << RCL_L_LIVE) & ~((RCL_NLINES)'(1) << RCL_L_READY);
		line_oe_out[RCL_L_HALT] = ctrl_wr[RCL_L_HALT] | fault_in;
		line_oe_out[RCL_L_LIVE] = ~powered_in;
		line_oe_out[RCL_L_READY] = ~local_ready_in | (phase_reg != RCL_READY && phase_reg != RCL_IDLE);
	end

	////////////////////////////////////////////////////////////////////////
	// run sequence
	always_comb begin
		phase_next = phase_reg;
		seq_fault = 1'b0;
		unique case (phase_reg)
			RCL_IDLE: begin
				if (asserted[RCL_L_READY]) begin
					phase_next = RCL_READY;
				end else if (rise[RCL_L_START]) begin
					seq_fault = 1'b1;
				end
			end
			RCL_READY: begin
				if (asserted[RCL_L_START] && !asserted[RCL_L_HALT]) begin
					phase_next = RCL_RUN;
				end else if (!asserted[RCL_L_READY]) begin
					phase_next = RCL_IDLE;
				end
			end
			RCL_RUN: begin
				if (asserted[RCL_L_STOP] || asserted[RCL_L_HALT]) begin
					phase_next = RCL_STOPPING;
				end
			end
			RCL_STOPPING: begin
				if (!asserted[RCL_L_STOP] && !asserted[RCL_L_START]) begin
					phase_next = RCL_IDLE;
				end
			end
		endcase
		if (!asserted[RCL_L_LIVE] && phase_next == RCL_RUN) begin
			phase_next = RCL_STOPPING;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			phase_reg <= RCL_IDLE;
		end else begin
			phase_reg <= phase_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reaction outputs, one register per reaction
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			halt_out <= 1'b0;
		end else begin
			halt_out <= asserted[RCL_L_HALT];
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			all_live_out <= 1'b0;
		end else begin
			all_live_out <= asserted[RCL_L_LIVE];
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			sys_ready_out <= 1'b0;
		end else begin
			sys_ready_out <= asserted[RCL_L_READY];
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			setup_req_out <= 1'b0;
		end else begin
			setup_req_out <= asserted[RCL_L_SETUP];
		end
	end

	// follows the next phase so start and the run phase change on the same edge
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			start_out <= 1'b0;
		end else begin
			start_out <= (phase_next == RCL_RUN);
		end
	end

	// a halt also asks for the stop reaction
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			stop_out <= 1'b0;
		end else begin
			stop_out <= asserted[RCL_L_STOP] | asserted[RCL_L_HALT];
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			inject_req_out <= 1'b0;
		end else begin
			inject_req_out <= asserted[RCL_L_INJECT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt status: set wins over clear-on-read
	always_comb begin
		events = {seq_fault, rise};
		status_next = status_reg;
		if (rd_en && rcl_hit(paddr_in, RCL_A_STATUS)) begin
			status_next = '0;
		end
		status_next = status_next | events;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			status_reg <= '0;
		end else begin
			status_reg <= status_next;
		end
	end

	logic [RCL_NEV-1:0] mask_full;
	assign mask_full = {1'b1, mask_reg};
	assign irq_out = |(status_reg & mask_full);

	////////////////////////////////////////////////////////////////////////
	// read data, registered on the setup cycle so it is stable in access
	always_comb begin
		rdata_next = '0;
		unique case (1'b1)
			rcl_hit(paddr_in, RCL_A_CTRL): rdata_next[RCL_NLINES-1:0] = ctrl_reg;
			rcl_hit(paddr_in, RCL_A_LINES): rdata_next[RCL_NLINES-1:0] = asserted;
			rcl_hit(paddr_in, RCL_A_STATUS): rdata_next[RCL_NEV-1:0] = status_reg | events;
			rcl_hit(paddr_in, RCL_A_MASK): rdata_next[RCL_NLINES-1:0] = mask_reg;
			rcl_hit(paddr_in, RCL_A_PHASE): rdata_next[1:0] = phase_reg;
			default: rdata_next = '0;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			prdata_out <= '0;
		end else if (setup_wr && !pwrite_in) begin
			prdata_out <= rdata_next;
		end
	end
	// the status read shows events of the setup cycle too, so the clear in access loses none
endmodule : rcl_top
`default_nettype wire

// File: dv/rcl_partner.sv
// far-side instruments pulling the shared coordination lines low beside the controller
`timescale 1ns/1ps
`default_nettype none
module rcl_partner (
	input wire logic [6:0] pull_in,
	input wire logic [6:0] dut_oe_in,
	output logic [6:0] wire_out
);
	// pull-ups win only while nobody sinks the line, so a released line never holds its old value
	assign wire_out = ~(pull_in | dut_oe_in);
endmodule : rcl_partner
`default_nettype wire

// File: dv/rcl_monitor.sv
// concurrent checks on the coordination line controller ports
`timescale 1ns/1ps
`default_nettype none
module rcl_monitor (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [6:0] line_in,
	input wire logic [6:0] line_out,
	input wire logic [6:0] line_oe_out,
	input wire logic fault_in,
	input wire logic halt_out,
	input wire logic all_live_out,
	input wire logic sys_ready_out,
	input wire logic setup_req_out,
	input wire logic stop_out,
	input wire logic start_out
);
	logic [1:0] age_reg;
	// outputs follow the wire only once the sync pipe has refilled after reset
	always_ff @(posedge clk_in) begin
		if (reset_in)
			age_reg <= 2'h0;
		else if (age_reg != 2'h3)
			age_reg <= age_reg + 2'h1;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in || age_reg != 2'h3);
	sequence run_go;
		$rose(start_out);
	endsequence
	sequence start_seen;
		!$past(line_in[1], 3) && $past(line_in[2], 3);
	endsequence
	////////////////////////////////////////////////////////////////////////
	halt_trace_a: assert property (halt_out == !$past(line_in[2], 3)) else $error("halt level wrong");
	live_trace_a: assert property (all_live_out == $past(line_in[3], 3)) else $error("live level wrong");
	ready_trace_a: assert property (sys_ready_out == $past(line_in[4], 3)) else $error("ready wrong");
	setup_trace_a: assert property (setup_req_out == !$past(line_in[0], 3)) else $error("setup wrong");
	stop_trace_a: assert property (stop_out == !($past(line_in[5], 3) && $past(line_in[2], 3)))
		else $error("stop level wrong");
	open_coll_a: assert property (line_out == 7'h00) else $error("line driven high");
	fault_pull_a: assert property (fault_in |-> line_oe_out[2]) else $error("fault not pulled");
	start_order_a: assert property (run_go |-> start_seen) else $error("run began unasked");
endmodule : rcl_monitor
bind rcl_top rcl_monitor u_rcl_monitor (.*);
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the coordination line controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rcl_pkg::*;
	logic clk_in, reset_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, err;
	logic fault_in, local_ready_in, powered_in, halt_out, all_live_out, sys_ready_out;
	logic setup_req_out, start_out, stop_out, inject_req_out, irq_out;
	logic [7:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, rd, c;
	logic [6:0] line_in, line_out, line_oe_out, pull, m;
	logic [6:0] hist[$];
	int num_errors, checks, seed;
	rcl_top u_rcl_top (.*);
	rcl_partner u_rcl_partner (.pull_in(pull), .dut_oe_in(line_oe_out), .wire_out(line_in));
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e)
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		if (s !== e)
			num_errors++;
	endtask : cmp
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb
	task automatic final_report;
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////////
	// model: each reaction output but start is the wire truth of three edges before
	always @(posedge clk_in) begin
		if (reset_in)
			hist = {};
		else begin
			if (hist.size() == 3) begin
				m = hist.pop_front() ^ 7'h67;
				cmp("levels", {m[6], m[5] | m[2], m[0], m[4], m[3], m[2]}, {inject_req_out, stop_out, setup_req_out,
					sys_ready_out, all_live_out, halt_out});
			end
			hist.push_back(line_in);
		end
	end
	initial begin
		repeat (3000) @(posedge clk_in);
		num_errors++;
		final_report();
	end
	initial begin
		seed = 32'h0C5A;
		reset_in = 1'b1;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		paddr_in = 8'h00;
		pwdata_in = 32'h0;
		pull = 7'h00;
		fault_in = 1'b0;
		local_ready_in = 1'b1;
		powered_in = 1'b1;
		repeat (5) @(posedge clk_in);
		reset_in <= 1'b0;
		apb(1'b0, RCL_A_CTRL, 32'h0);
		cmp("ctrl", {25'h0, RCL_CTRL_RESET}, rd);
		apb(1'b0, RCL_A_MASK, 32'h0);
		cmp("mask", {25'h0, RCL_MASK_RESET}, rd);
		apb(1'b1, 8'h14, 32'hFFFFFFFF);
		cmp("slverr", 32'h1, {31'h0, err});
		apb(1'b0, 8'h14, 32'h0);
		cmp("unmapped", 32'h0, rd);
		for (int i = 0; i < 30; i++) begin
			c = 32'($random(seed));
			apb(1'b1, RCL_A_CTRL, c);
			pull <= 7'($random(seed));
			fault_in <= 1'($random(seed));
			powered_in <= 1'($random(seed));
			local_ready_in <= 1'($random(seed));
			repeat (8) @(posedge clk_in);
			cmp("drive", {c[6:5], !powered_in, c[2] | fault_in, c[1:0]}, {line_oe_out[6:5], line_oe_out[3:0]});
			apb(1'b0, RCL_A_LINES, 32'h0);
			cmp("lines", {25'h0, line_in ^ 7'h67}, rd);
		end
		// stop first, so a run left over from the random phase ends in a known state
		pull <= 7'h20;
		fault_in <= 1'b0;
		powered_in <= 1'b1;
		local_ready_in <= 1'b1;
		apb(1'b1, RCL_A_CTRL, 32'h0);
		repeat (6) @(posedge clk_in);
		pull <= 7'h00;
		repeat (12) @(posedge clk_in);
		apb(1'b0, RCL_A_STATUS, 32'h0);
		apb(1'b0, RCL_A_STATUS, 32'h0);
		cmp("status clear", 32'h0, rd);
		apb(1'b1, RCL_A_MASK, 32'h0);
		pull <= 7'h04;
		repeat (6) @(posedge clk_in);
		cmp("irq masked", 32'h0, {31'h0, irq_out});
		apb(1'b1, RCL_A_MASK, 32'h4);
		@(posedge clk_in);
		cmp("irq", 32'h1, {31'h0, irq_out});
		apb(1'b0, RCL_A_STATUS, 32'h0);
		cmp("status", 32'h4, rd);
		@(posedge clk_in);
		cmp("irq cleared", 32'h0, {31'h0, irq_out});
		pull <= 7'h00;
		repeat (12) @(posedge clk_in);
		apb(1'b0, RCL_A_PHASE, 32'h0);
		cmp("phase ready", 32'h1, rd);
		cmp("ready free", 32'h0, {31'h0, line_oe_out[RCL_L_READY]});
		pull <= 7'h02;
		repeat (6) @(posedge clk_in);
		cmp("start", 32'h1, {31'h0, start_out});
		apb(1'b0, RCL_A_PHASE, 32'h0);
		cmp("phase run", 32'h3, rd);
		cmp("ready pulled", 32'h1, {31'h0, line_oe_out[RCL_L_READY]});
		pull <= 7'h20;
		repeat (6) @(posedge clk_in);
		apb(1'b0, RCL_A_PHASE, 32'h0);
		cmp("phase stopping", 32'h2, rd);
		pull <= 7'h00;
		repeat (12) @(posedge clk_in);
		apb(1'b0, RCL_A_PHASE, 32'h0);
		cmp("phase again", 32'h1, rd);
		pull <= 7'h06;
		repeat (6) @(posedge clk_in);
		cmp("start refused", 32'h0, {31'h0, start_out});
		// ready withdrawn: a start now is out of order and must raise the sequence fault
		pull <= 7'h10;
		repeat (6) @(posedge clk_in);
		apb(1'b0, RCL_A_STATUS, 32'h0);
		pull <= 7'h12;
		repeat (6) @(posedge clk_in);
		cmp("seq irq", 32'h1, {31'h0, irq_out});
		cmp("seq no start", 32'h0, {31'h0, start_out});
		apb(1'b0, RCL_A_STATUS, 32'h0);
		cmp("seq status", 32'h82, rd);
		final_report();
	end
endmodule : tb_top
`default_nettype wire
